// File: core/evt_defines.svh
// Register offsets, field positions and reset values of the VLAN translation lookup
`ifndef EVT_DEFINES_SVH
`define EVT_DEFINES_SVH

// Word indexes; the byte address is four times the index
`define EVT_LARGE_BASE   30'h0043e27
`define EVT_SMALL_BASE   30'h0044627
`define EVT_ANSWER_BASE  30'h0044727
`define EVT_SELECT_BASE  30'h0044765
`define EVT_MASK_BASE    30'h0044767
`define EVT_TCAM_BASE    30'h00447d3
`define EVT_LARGE_WORDS  30'h0000800
`define EVT_SMALL_WORDS  30'h0000100
`define EVT_ANSWER_WORDS 30'h0000008
`define EVT_SELECT_WORDS 30'h0000001
`define EVT_MASK_WORDS   30'h0000002
`define EVT_TCAM_WORDS   30'h0000010

// Hash entry fields
`define EVT_HE_VALID 0
`define EVT_HE_KEY   19:1
`define EVT_HE_VID   31:20
`define EVT_HE_ETH   47:32

// Search mask fields
`define EVT_MSK_PORT_S 5:0
`define EVT_MSK_PORT_L 11:6
`define EVT_MSK_VID_S  23:12
`define EVT_MSK_VID_L  35:24
`define EVT_MSK_TYPE_S 36
`define EVT_MSK_TYPE_L 37

// TCAM entry fields
`define EVT_TC_VALID 0
`define EVT_TC_PMASK 6:1
`define EVT_TC_PORT  12:7
`define EVT_TC_VMASK 24:13
`define EVT_TC_VID   36:25
`define EVT_TC_TMASK 37
`define EVT_TC_TYPE  38

// Answer table fields
`define EVT_TA_VID 11:0
`define EVT_TA_ETH 27:12

// Select bits
`define EVT_SEL_SOURCE 0
`define EVT_SEL_SIZE   1

// Reset values
`define EVT_MASK_RESET   38'h3fffffffff
`define EVT_SELECT_RESET 2'h0
`define EVT_TCAM_RESET   39'h2001ffe07e
`define EVT_ANSWER_RESET 28'h0000000

// Cycles from lookup request to result
`define EVT_LOOKUP_LAT 2

`endif

// File: core/evt_pkg.sv
// Types shared by the VLAN translation lookup
package evt_pkg;
  typedef enum logic [1:0] {EVT_BUS_IDLE, EVT_BUS_WRITE, EVT_BUS_READ} evt_bus_state_t;
  typedef logic [18:0] evt_key_t;
  typedef logic [47:0] evt_hash_entry_t;
  typedef logic [38:0] evt_tcam_entry_t;
  typedef logic [27:0] evt_answer_t;
endpackage : evt_pkg

// File: core/evt_hash_bank.sv
// Two-bucket compare of one hash table row
`timescale 1ns/100ps
`default_nettype none
`include "evt_defines.svh"
module evt_hash_bank
  import evt_pkg::*;
(
  input  wire evt_key_t        key,
  input  wire evt_key_t        mask,
  input  wire evt_hash_entry_t ent0,
  input  wire evt_hash_entry_t ent1,
  output logic                 hit,
  output logic [11:0]          vid,
  output logic [15:0]          eth
);
  logic m0;
  logic m1;

  // Zero mask bits drop out of the compare
  assign m0 = ent0[`EVT_HE_VALID] && (((ent0[`EVT_HE_KEY] ^ key) & mask) == '0);
  assign m1 = ent1[`EVT_HE_VALID] && (((ent1[`EVT_HE_KEY] ^ key) & mask) == '0);

  always_comb begin
    hit = m0 | m1;
    // Higher bucket wins
    if (m1) begin
      vid = ent1[`EVT_HE_VID];
      eth = ent1[`EVT_HE_ETH];
    end else begin
      vid = ent0[`EVT_HE_VID];
      eth = ent0[`EVT_HE_ETH];
    end
  end
endmodule : evt_hash_bank
`default_nettype wire

// File: core/evt_tcam_match.sv
// Eight-entry masked TCAM with its answer table read-out
`timescale 1ns/100ps
`default_nettype none
`include "evt_defines.svh"
module evt_tcam_match
  import evt_pkg::*;
(
  input  wire evt_key_t              key,
  input  wire evt_tcam_entry_t [7:0] entry,
  input  wire evt_answer_t [7:0]     answer,
  output logic                       hit,
  output logic [2:0]                 idx,
  output logic [11:0]                vid,
  output logic [15:0]                eth
);
  logic [7:0] match;

  // All entries compared at once
  for (genvar g = 0; g < 8; g++) begin : g_ent
    assign match[g] = entry[g][`EVT_TC_VALID]
      && (((entry[g][`EVT_TC_PORT] ^ key[5:0]) & entry[g][`EVT_TC_PMASK]) == '0)
      && (((entry[g][`EVT_TC_VID] ^ key[17:6]) & entry[g][`EVT_TC_VMASK]) == '0)
      && (((entry[g][`EVT_TC_TYPE] ^ key[18]) & entry[g][`EVT_TC_TMASK]) == 1'b0);
  end

  always_comb begin
    hit = 1'b0;
    idx = 3'h0;
    // Downward scan leaves the lowest match
    for (int i = 7; i >= 0; i--) begin
      if (match[i]) begin
        hit = 1'b1;
        idx = i[2:0];
      end
    end
    vid = answer[idx][`EVT_TA_VID];
    eth = answer[idx][`EVT_TA_ETH];
  end
endmodule : evt_tcam_match
`default_nettype wire

// File: core/evt_lookup.sv
// Egress VLAN translation lookup with AHB-Lite register access
// Operation
// - Key ANDed with search mask before lookup
// - Separate small and large masks, reset ones
// - Mask one compares bit, zero ignores
// - Source select: zero TCAM, one hash; a miss in the chosen table falls back to TCAM, small, then large hits
// - Size select: zero small, one large
// - Small table 128 entries, six-bit hash
// - Highest matching bucket wins
// - Invalid hash entries never match
// - Entry key: port, VID, tag type
// - Tag type zero customer, one service
// - Hash hit gives VID and EtherType
// - Key from modified outer tag, port
// - Eight TCAM entries searched in parallel
// - TCAM entry holds per-field masks, values
// - TCAM hit indexes eight-entry answer table
// - Large table 1024 entries, nine-bit hash
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "evt_defines.svh"
module evt_lookup
  import evt_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        lk_valid,
  input  wire logic [5:0]  lk_port,
  input  wire logic [11:0] lk_vid,
  input  wire logic        lk_tag_type,
  input  wire logic [15:0] lk_replacement_ether_type,
  output logic             rs_valid,
  output logic             rs_hit,
  output logic [11:0]      rs_vid,
  output logic [15:0]      rs_replacement_ether_type
);
  evt_bus_state_t        bus_st_ff;
  logic [29:0]           ap_idx_ff;
  logic [31:0]           hrdata_ff;
  logic [1:0]            translation_result_select_ff;
  logic [37:0]           translation_search_mask_ff;
  evt_tcam_entry_t [7:0] translation_tcam_entries_ff;
  evt_answer_t [7:0]     tcam_answer_table_ff;
  logic [47:1]           small_hash_translation_table [128];
  logic [127:0]          small_vld_ff;
  logic [47:1]           large_hash_translation_table [1024];
  logic [1023:0]         large_vld_ff;
  logic                  s1_valid_ff;
  evt_key_t              s1_key_ff;
  logic [15:0]           s1_eth_ff;
  evt_hash_entry_t       s1_sm0_ff;
  evt_hash_entry_t       s1_sm1_ff;
  evt_hash_entry_t       s1_lg0_ff;
  evt_hash_entry_t       s1_lg1_ff;
  logic                  rs_valid_ff;
  logic                  rs_hit_ff;
  logic [11:0]           rs_vid_ff;
  logic [15:0]           rs_eth_ff;
  logic                  accept;
  logic [29:0]           sm_off;
  logic [29:0]           lg_off;
  logic [29:0]           an_off;
  logic [29:0]           sl_off;
  logic [29:0]           mk_off;
  logic [29:0]           tc_off;
  logic [31:0]           rd_word;
  logic                  wr_en;
  evt_key_t              lk_key;
  evt_key_t              sm_msk;
  evt_key_t              lg_msk;
  logic [5:0]            sm_row;
  logic [8:0]            lg_row;
  logic                  sm_hit;
  logic                  lg_hit;
  logic                  tc_hit;
  logic [2:0]            tc_idx;
  logic [11:0]           sm_vid;
  logic [11:0]           lg_vid;
  logic [11:0]           tc_vid;
  logic [15:0]           sm_eth;
  logic [15:0]           lg_eth;
  logic [15:0]           tc_eth;
  logic                  sel_hit;
  logic [11:0]           sel_vid;
  logic [15:0]           sel_eth;

  function automatic logic [5:0] hash6(evt_key_t k);
    return k[5:0] ^ k[11:6] ^ k[17:12] ^ {5'h00, k[18]};
  endfunction : hash6

  function automatic logic [8:0] hash9(evt_key_t k);
    return k[8:0] ^ k[17:9] ^ {8'h00, k[18]};
  endfunction : hash9

  // AHB-Lite slave: writes take no wait state, reads take one
  assign accept    = hsel && htrans[1] && hready;
  assign hreadyout = (bus_st_ff != EVT_BUS_READ);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;
  assign wr_en     = (bus_st_ff == EVT_BUS_WRITE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_st_ff <= EVT_BUS_IDLE;
    end else begin
      case (bus_st_ff)
        EVT_BUS_READ: bus_st_ff <= EVT_BUS_IDLE;
        default: begin
          if (accept) begin
            bus_st_ff <= hwrite ? EVT_BUS_WRITE : EVT_BUS_READ;
          end else begin
            bus_st_ff <= EVT_BUS_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_idx_ff <= 30'h0;
    end else if (accept) begin
      ap_idx_ff <= haddr[31:2];
    end
  end

  // Region offsets; unsigned wrap makes one compare per region
  assign sm_off = ap_idx_ff - `EVT_SMALL_BASE;
  assign lg_off = ap_idx_ff - `EVT_LARGE_BASE;
  assign an_off = ap_idx_ff - `EVT_ANSWER_BASE;
  assign sl_off = ap_idx_ff - `EVT_SELECT_BASE;
  assign mk_off = ap_idx_ff - `EVT_MASK_BASE;
  assign tc_off = ap_idx_ff - `EVT_TCAM_BASE;

  always_comb begin
    rd_word = 32'h0;
    if (sm_off < `EVT_SMALL_WORDS) begin
      rd_word = sm_off[0] ? {16'h0, small_hash_translation_table[sm_off[7:1]][47:32]}
                          : {small_hash_translation_table[sm_off[7:1]][31:1],
                             small_vld_ff[sm_off[7:1]]};
    end else if (lg_off < `EVT_LARGE_WORDS) begin
      rd_word = lg_off[0] ? {16'h0, large_hash_translation_table[lg_off[10:1]][47:32]}
                          : {large_hash_translation_table[lg_off[10:1]][31:1],
                             large_vld_ff[lg_off[10:1]]};
    end else if (an_off < `EVT_ANSWER_WORDS) begin
      rd_word = {4'h0, tcam_answer_table_ff[an_off[2:0]]};
    end else if (sl_off < `EVT_SELECT_WORDS) begin
      rd_word = {30'h0, translation_result_select_ff};
    end else if (mk_off < `EVT_MASK_WORDS) begin
      rd_word = mk_off[0] ? {26'h0, translation_search_mask_ff[37:32]}
                          : translation_search_mask_ff[31:0];
    end else if (tc_off < `EVT_TCAM_WORDS) begin
      rd_word = tc_off[0] ? {25'h0, translation_tcam_entries_ff[tc_off[3:1]][38:32]}
                          : translation_tcam_entries_ff[tc_off[3:1]][31:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0;
    end else if (bus_st_ff == EVT_BUS_READ) begin
      hrdata_ff <= rd_word;
    end
  end

  // Hash table bodies carry no reset; valid bits do
  always_ff @(posedge hclk) begin
    if (wr_en && (sm_off < `EVT_SMALL_WORDS)) begin
      if (sm_off[0]) begin
        small_hash_translation_table[sm_off[7:1]][47:32] <= hwdata[15:0];
      end else begin
        small_hash_translation_table[sm_off[7:1]][31:1] <= hwdata[31:1];
      end
    end
    if (wr_en && (lg_off < `EVT_LARGE_WORDS)) begin
      if (lg_off[0]) begin
        large_hash_translation_table[lg_off[10:1]][47:32] <= hwdata[15:0];
      end else begin
        large_hash_translation_table[lg_off[10:1]][31:1] <= hwdata[31:1];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      small_vld_ff <= '0;
      large_vld_ff <= '0;
    end else if (wr_en) begin
      if ((sm_off < `EVT_SMALL_WORDS) && !sm_off[0]) begin
        small_vld_ff[sm_off[7:1]] <= hwdata[0];
      end
      if ((lg_off < `EVT_LARGE_WORDS) && !lg_off[0]) begin
        large_vld_ff[lg_off[10:1]] <= hwdata[0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      translation_search_mask_ff   <= `EVT_MASK_RESET;
      translation_result_select_ff <= `EVT_SELECT_RESET;
    end else if (wr_en) begin
      if (mk_off == 30'h0) begin
        translation_search_mask_ff[31:0] <= hwdata;
      end
      if (mk_off == 30'h1) begin
        translation_search_mask_ff[37:32] <= hwdata[5:0];
      end
      if (sl_off == 30'h0) begin
        translation_result_select_ff <= hwdata[1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      translation_tcam_entries_ff <= {8{`EVT_TCAM_RESET}};
      tcam_answer_table_ff        <= {8{`EVT_ANSWER_RESET}};
    end else if (wr_en) begin
      if ((tc_off < `EVT_TCAM_WORDS) && !tc_off[0]) begin
        translation_tcam_entries_ff[tc_off[3:1]][31:0] <= hwdata;
      end
      if ((tc_off < `EVT_TCAM_WORDS) && tc_off[0]) begin
        translation_tcam_entries_ff[tc_off[3:1]][38:32] <= hwdata[6:0];
      end
      if (an_off < `EVT_ANSWER_WORDS) begin
        tcam_answer_table_ff[an_off[2:0]] <= hwdata[27:0];
      end
    end
  end

  // Stage 1: form masked keys, hash, read both buckets
  assign lk_key = {lk_tag_type, lk_vid, lk_port};
  assign sm_msk = {translation_search_mask_ff[`EVT_MSK_TYPE_S],
                   translation_search_mask_ff[`EVT_MSK_VID_S],
                   translation_search_mask_ff[`EVT_MSK_PORT_S]};
  assign lg_msk = {translation_search_mask_ff[`EVT_MSK_TYPE_L],
                   translation_search_mask_ff[`EVT_MSK_VID_L],
                   translation_search_mask_ff[`EVT_MSK_PORT_L]};
  assign sm_row = hash6(lk_key & sm_msk);
  assign lg_row = hash9(lk_key & lg_msk);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_valid_ff <= 1'b0;
      s1_key_ff   <= '0;
      s1_eth_ff   <= 16'h0;
      s1_sm0_ff   <= '0;
      s1_sm1_ff   <= '0;
      s1_lg0_ff   <= '0;
      s1_lg1_ff   <= '0;
    end else begin
      s1_valid_ff <= lk_valid;
      s1_key_ff   <= lk_key;
      s1_eth_ff   <= lk_replacement_ether_type;
      // Top address bit is the bucket number
      s1_sm0_ff <= {small_hash_translation_table[{1'b0, sm_row}],
                    small_vld_ff[{1'b0, sm_row}]};
      s1_sm1_ff <= {small_hash_translation_table[{1'b1, sm_row}],
                    small_vld_ff[{1'b1, sm_row}]};
      s1_lg0_ff <= {large_hash_translation_table[{1'b0, lg_row}],
                    large_vld_ff[{1'b0, lg_row}]};
      s1_lg1_ff <= {large_hash_translation_table[{1'b1, lg_row}],
                    large_vld_ff[{1'b1, lg_row}]};
    end
  end

  // Stage 2: compare and choose
  evt_hash_bank u_small (
    .key  (s1_key_ff & sm_msk),
    .mask (sm_msk),
    .ent0 (s1_sm0_ff),
    .ent1 (s1_sm1_ff),
    .hit  (sm_hit),
    .vid  (sm_vid),
    .eth  (sm_eth)
  );

  evt_hash_bank u_large (
    .key  (s1_key_ff & lg_msk),
    .mask (lg_msk),
    .ent0 (s1_lg0_ff),
    .ent1 (s1_lg1_ff),
    .hit  (lg_hit),
    .vid  (lg_vid),
    .eth  (lg_eth)
  );

  evt_tcam_match u_tcam (
    .key    (s1_key_ff),
    .entry  (translation_tcam_entries_ff),
    .answer (tcam_answer_table_ff),
    .hit    (tc_hit),
    .idx    (tc_idx),
    .vid    (tc_vid),
    .eth    (tc_eth)
  );

  always_comb begin
    sel_hit = 1'b1;
    sel_vid = s1_key_ff[17:6];
    sel_eth = s1_eth_ff;
    if (!translation_result_select_ff[`EVT_SEL_SOURCE] && tc_hit) begin
      sel_vid = tc_vid;
      sel_eth = tc_eth;
    end else if (translation_result_select_ff[`EVT_SEL_SOURCE]
                 && translation_result_select_ff[`EVT_SEL_SIZE] && lg_hit) begin
      sel_vid = lg_vid;
      sel_eth = lg_eth;
    end else if (translation_result_select_ff[`EVT_SEL_SOURCE]
                 && !translation_result_select_ff[`EVT_SEL_SIZE] && sm_hit) begin
      sel_vid = sm_vid;
      sel_eth = sm_eth;
    end else if (tc_hit) begin
      sel_vid = tc_vid;
      sel_eth = tc_eth;
    end else if (sm_hit) begin
      sel_vid = sm_vid;
      sel_eth = sm_eth;
    end else if (lg_hit) begin
      sel_vid = lg_vid;
      sel_eth = lg_eth;
    end else begin
      sel_hit = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rs_valid_ff <= 1'b0;
      rs_hit_ff   <= 1'b0;
      rs_vid_ff   <= 12'h0;
      rs_eth_ff   <= 16'h0;
    end else begin
      rs_valid_ff <= s1_valid_ff;
      rs_hit_ff   <= s1_valid_ff && sel_hit;
      rs_vid_ff   <= sel_vid;
      rs_eth_ff   <= sel_eth;
    end
  end

  assign rs_valid   = rs_valid_ff;
  assign rs_hit     = rs_hit_ff;
  assign rs_vid     = rs_vid_ff;
  assign rs_replacement_ether_type = rs_eth_ff;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_read_taken;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_miss_out;
    lk_valid ##2 (rs_valid && !rs_hit);
  endsequence
  sequence s_stage2(logic c);
    s1_valid_ff && c;
  endsequence

  a_read_wait: assert property (s_read_taken |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_lookup_lat: assert property (lk_valid |-> ##2 rs_valid)
    else $error("lookup result late");
  a_miss_keep: assert property (s_miss_out |-> rs_vid == $past(lk_vid, 2)
                                && rs_replacement_ether_type == $past(lk_replacement_ether_type, 2))
    else $error("miss changed the tag");
  a_tcam_pick: assert property (s_stage2(!translation_result_select_ff[0] && tc_hit)
                                |=> rs_hit && rs_vid == $past(tc_vid))
    else $error("tcam answer not used");
  a_small_pick: assert property (
      s_stage2(translation_result_select_ff == 2'h1 && sm_hit)
      |=> rs_vid == $past(sm_vid))
    else $error("small table answer not used");
  a_large_pick: assert property (
      s_stage2(translation_result_select_ff == 2'h3 && lg_hit)
      |=> rs_vid == $past(lg_vid) && rs_replacement_ether_type == $past(lg_eth))
    else $error("large table answer not used");
  a_bank_mask: assert property (
      sm_hit |-> ((s1_sm0_ff[19:1] ^ s1_key_ff) & sm_msk) == '0
      || ((s1_sm1_ff[19:1] ^ s1_key_ff) & sm_msk) == '0)
    else $error("masked compare wrong");
  a_bucket_high: assert property (
      s1_sm1_ff[0] && ((s1_sm1_ff[19:1] ^ s1_key_ff) & sm_msk) == '0
      |-> sm_vid == s1_sm1_ff[31:20])
    else $error("higher bucket lost");
  a_hash_valid: assert property (lg_hit |-> s1_lg0_ff[0] || s1_lg1_ff[0])
    else $error("invalid entry hit");
  a_tcam_valid: assert property (tc_hit |-> translation_tcam_entries_ff[tc_idx][0])
    else $error("invalid tcam entry hit");
  a_mask_reset: assert property (
      $rose(hresetn) |-> translation_search_mask_ff == `EVT_MASK_RESET)
    else $error("mask reset wrong");
endmodule : evt_lookup
`default_nettype wire

// File: verif/evt_pipe_model.sv
// Egress pipeline stand-in: issues lookups and collects the answers
`timescale 1ns/100ps
`default_nettype none
`include "evt_defines.svh"
module evt_pipe_model (
  input  wire logic        hclk,
  output var  logic        lk_valid,
  output var  logic [5:0]  lk_port,
  output var  logic [11:0] lk_vid,
  output var  logic        lk_tag_type,
  output var  logic [15:0] lk_replacement_ether_type,
  input  wire logic        rs_valid,
  input  wire logic        rs_hit,
  input  wire logic [11:0] rs_vid,
  input  wire logic [15:0] rs_replacement_ether_type
);
  initial {lk_valid, lk_port, lk_vid, lk_tag_type, lk_replacement_ether_type} = 36'h0;

  // One-cycle request; answer sampled at its fixed latency
  task automatic lookup(input logic [5:0] p, input logic [11:0] v, input logic t,
                        input logic [15:0] e, output logic [29:0] res);
    lk_valid <= 1'b1;
    {lk_port, lk_vid, lk_tag_type, lk_replacement_ether_type} <= {p, v, t, e};
    @(posedge hclk);
    lk_valid <= 1'b0;
    // Idle key lines inverted so a stale key cannot pass for a live one
    {lk_port, lk_vid, lk_tag_type, lk_replacement_ether_type} <= ~{p, v, t, e};
    // Result stands one cycle only: take it at the edge that ends that cycle
    repeat (`EVT_LOOKUP_LAT) @(posedge hclk);
    res = {rs_valid, rs_hit, rs_vid, rs_replacement_ether_type};
  endtask : lookup
endmodule : evt_pipe_model
`default_nettype wire

// File: verif/evt_lookup_test.sv
// Self-checking bench of the egress VLAN translation lookup
`timescale 1ns/100ps
`default_nettype none
`include "evt_defines.svh"
module evt_lookup_test;
  typedef struct {
    logic [1:0]  sel;
    logic [18:0] k;
    logic        h;
    logic [11:0] v;
    logic [15:0] e;
  } evt_row_t;
  localparam logic [18:0] key_a = {1'b1, 12'h123, 6'h05};
  localparam logic [18:0] key_b = {1'b0, 12'h456, 6'h07};
  localparam logic [18:0] key_c = {1'b0, 12'h123, 6'h05};
  localparam logic [18:0] key_m = {1'b1, 12'h000, 6'h05};
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        lk_valid, lk_tag_type, rs_valid, rs_hit;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [5:0]  lk_port;
  logic [11:0] lk_vid, rs_vid;
  logic [15:0] lk_replacement_ether_type, rs_replacement_ether_type;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [29:0] res;
  int          error_cnt, check_count;
  evt_row_t    rows [6] = '{
    '{2'h0, key_a, 1'b1, 12'hc03, 16'h3333},
    '{2'h1, key_a, 1'b1, 12'ha01, 16'h1111},
    '{2'h3, key_a, 1'b1, 12'hb02, 16'h2222},
    '{2'h2, key_a, 1'b1, 12'hc03, 16'h3333},
    '{2'h1, key_c, 1'b0, 12'h123, 16'h0abc},
    '{2'h0, key_b, 1'b0, 12'h456, 16'h0abc}};

  evt_lookup u_evt_lookup (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .lk_valid(lk_valid),
    .lk_port(lk_port), .lk_vid(lk_vid), .lk_tag_type(lk_tag_type),
    .lk_replacement_ether_type(lk_replacement_ether_type), .rs_valid(rs_valid), .rs_hit(rs_hit), .rs_vid(rs_vid),
    .rs_replacement_ether_type(rs_replacement_ether_type));

  evt_pipe_model u_evt_pipe_model (
    .hclk(hclk), .lk_valid(lk_valid), .lk_port(lk_port), .lk_vid(lk_vid),
    .lk_tag_type(lk_tag_type), .lk_replacement_ether_type(lk_replacement_ether_type), .rs_valid(rs_valid),
    .rs_hit(rs_hit), .rs_vid(rs_vid), .rs_replacement_ether_type(rs_replacement_ether_type));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  initial {hsel, hwrite, htrans, hsize, haddr, hwdata} = {4'h0, 3'h2, 64'h0};

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s saw %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // Single word transfer; waits on hready, no cycle count assumed
  task automatic bus(input logic wr, input logic [29:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {idx, 2'b00};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus

  task automatic wr2(input logic [29:0] idx, input logic [63:0] d);
    bus(1'b1, idx, d[31:0]);
    bus(1'b1, idx + 30'h1, d[63:32]);
  endtask : wr2

  task automatic rdchk(input logic [29:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rd, exp, "register read");
  endtask : rdchk

  // Row from the folded key; bucket is the top entry bit
  task automatic put_hash(input logic lg, input logic b, input logic [18:0] k,
                          input logic [11:0] v, input logic [15:0] e, input logic ok);
    logic [9:0] n;
    n = lg ? {b, k[8:0] ^ k[17:9] ^ {8'h0, k[18]}}
           : {3'h0, b, k[5:0] ^ k[11:6] ^ k[17:12] ^ {5'h0, k[18]}};
    wr2((lg ? `EVT_LARGE_BASE : `EVT_SMALL_BASE) + {19'h0, n, 1'b0},
        {16'h0, e, v, k, ok});
  endtask : put_hash

  task automatic put_tcam(input logic [2:0] i, input logic [38:0] w,
                          input logic [11:0] v, input logic [15:0] e);
    wr2(`EVT_TCAM_BASE + {26'h0, i, 1'b0}, {25'h0, w});
    bus(1'b1, `EVT_ANSWER_BASE + {27'h0, i}, {4'h0, e, v});
  endtask : put_tcam

  task automatic look(input logic [1:0] sel, input logic [18:0] k, input logic h,
                      input logic [11:0] xv, input logic [15:0] xe);
    bus(1'b1, `EVT_SELECT_BASE, {30'h0, sel});
    u_evt_pipe_model.lookup(k[5:0], k[17:6], k[18], 16'h0abc, res);
    chk(32'(res[29:28]), {30'h0, 1'b1, h}, "valid and hit");
    chk({4'h0, res[27:0]}, {4'h0, xv, xe}, "vid and ethertype");
  endtask : look

  initial begin
    #100000;
    error_cnt++;
    $display("Error at %0t: watchdog expired", $time);
    conclude();
  end

  initial begin
    hresetn = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    put_hash(1'b0, 1'b0, key_a, 12'ha00, 16'h1100, 1'b1);
    put_hash(1'b0, 1'b1, key_a, 12'ha01, 16'h1111, 1'b1);
    put_hash(1'b1, 1'b0, key_a, 12'hb02, 16'h2222, 1'b1);
    put_tcam(3'h3, {key_a[18], 1'b1, key_a[17:6], 12'hfff, key_a[5:0], 7'h7f},
             12'hc03, 16'h3333);
    foreach (rows[i]) begin
      look(rows[i].sel, rows[i].k, rows[i].h, rows[i].v, rows[i].e);
    end
    $display("Test table rows done");
    put_hash(1'b0, 1'b1, key_a, 12'ha01, 16'h1111, 1'b0);
    look(2'h1, key_a, 1'b1, 12'ha00, 16'h1100);
    put_tcam(3'h6, 39'h1, 12'hd06, 16'h6666);
    look(2'h0, key_a, 1'b1, 12'hc03, 16'h3333);
    look(2'h0, key_b, 1'b1, 12'hd06, 16'h6666);
    look(2'h3, key_b, 1'b1, 12'hd06, 16'h6666);
    $display("Test invalid and tcam done");
    // Small VID mask cleared; large masks kept whole
    bus(1'b1, `EVT_MASK_BASE, 32'hff000fff);
    put_hash(1'b0, 1'b0, key_m, 12'ha55, 16'h5555, 1'b1);
    look(2'h1, {1'b1, 12'h777, 6'h05}, 1'b1, 12'ha55, 16'h5555);
    look(2'h3, key_a, 1'b1, 12'hb02, 16'h2222);
    rdchk(`EVT_ANSWER_BASE + 30'h3, 32'h03333c03);
    bus(1'b1, `EVT_SELECT_BASE + 30'h1, 32'hffffffff);
    rdchk(`EVT_SELECT_BASE + 30'h1, 32'h0);
    $display("Test masks and map done");
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    chk({29'h0, hreadyout, hresp, rs_valid}, 32'h4, "outputs in reset");
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(`EVT_MASK_BASE, 32'hffffffff);
    rdchk(`EVT_MASK_BASE + 30'h1, 32'h0000003f);
    rdchk(`EVT_SELECT_BASE, 32'h0);
    rdchk(`EVT_TCAM_BASE, 32'h01ffe07e);
    rdchk(`EVT_TCAM_BASE + 30'h1, 32'h00000020);
    look(2'h1, key_a, 1'b0, 12'h123, 16'h0abc);
    $display("Test reset done");
    conclude();
  end
endmodule : evt_lookup_test
`default_nettype wire
